// ---- logic/aic_conditioner.sv ----
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
// Overview of operation
// - Every sample is a signed two's-complement 16-bit value, sign included.
// - Mains rejection paces conversions to half a 50 or 60 Hz period, 50 at reset.
// - Each input is a running average of its last N samples, N=2^k to 128.
// - A nonzero delta flags a change beyond plus or minus delta; 0 disables.
// - The range selection per module sets the under limit; the over limit is fixed.
// - Bipolar full scale is 32000; under below -32256, over above 32256.
// - An uncalibrated channel shows both range flags at once.
// - On module failure each input delivers its hold-last or preset value.
// - A masked input delivers its preset value in normal operation.
// - In sleep no conversion runs and reads return the preset values.
// - In freeze each input delivers its hold-last or preset value.
module aic_conditioner #(
	parameter int          CH            = aic_pkg::CHANNELS,
	parameter int          CONV50_CYCLES = aic_pkg::CONV50_CYCLES,
	parameter int          CONV60_CYCLES = aic_pkg::CONV60_CYCLES,
	parameter logic        VOLTAGE_MODULE = 1'b0
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output wire logic [31:0]            wb_dat_o,
	output wire logic                   wb_ack_o,
	output wire logic                   irq,
	output wire logic                   convStart,
	input  wire logic                   sampleValid,
	input  wire logic [$clog2(CH)-1:0]  sampleChannel,
	input  wire logic signed [15:0]     sampleData,
	input  wire logic                   moduleFault,
	output wire logic [CH-1:0]          underRangeFlag,
	output wire logic [CH-1:0]          overRangeFlag
);
	localparam int CW = $clog2(CH);

	if (!(CH == 8 || CH == 16) || CONV50_CYCLES < 2 || CONV60_CYCLES < 2
		|| CONV50_CYCLES > 1048575 || CONV60_CYCLES > 1048575)
	begin : g_check
		$error("aic_conditioner: unsupported parameter values");
	end

	typedef struct packed {
		logic                   ack;
		logic [31:0]            rdata;
		logic                   irq;
		logic                   conv;
		logic [19:0]            tick;
		logic                   mains60;
		logic [2:0]             smoothLog;
		logic [2:0]             range;
		logic                   sleep;
		logic                   freeze;
		logic [1:0]             faultSync;
		logic [CH-1:0]          presetSel;
		logic [CH-1:0]          mask;
		logic [CH-1:0]          calib;
		logic [CH-1:0]          chg;
		logic [CH-1:0]          chgMask;
		logic [CH-1:0]          under;
		logic [CH-1:0]          over;
		logic [CH-1:0][6:0]     ptr;
		logic [CH-1:0][7:0]     fill;
		logic [CH-1:0][22:0]    sum;
		logic [CH-1:0][15:0]    refVal;
		logic [CH-1:0][15:0]    delta;
		logic [CH-1:0][15:0]    preset;
		logic [CH-1:0][15:0]    live;
	} aic_state_s;

	aic_state_s s_q;
	aic_state_s s_d;

	// sample history; no reset, entries are only read once fill covers them
	logic signed [15:0] hist [CH*128];

	logic                   fault;
	logic                   take;
	logic [CW-1:0]          ch;
	logic [7:0]             winLen;
	logic                   full;
	logic signed [15:0]     oldSample;
	logic signed [22:0]     newSum;
	logic signed [15:0]     avgNow;
	logic signed [16:0]     diff;
	logic [16:0]            diffAbs;
	logic                   changeHit;
	logic signed [15:0]     underLim;
	logic                   req;
	logic                   wr;
	logic [31:0]            byteMask;
	logic [3:0]             bankCh;
	logic                   bankOk;
	logic                   restart;
	logic [19:0]            period;

	assign wb_dat_o       = s_q.rdata;
	assign wb_ack_o       = s_q.ack;
	assign irq            = s_q.irq;
	assign convStart      = s_q.conv;
	assign underRangeFlag = s_q.under;
	assign overRangeFlag  = s_q.over;

	function automatic logic [15:0] deliver(input aic_state_s st,
		input logic flt, input int c);
		logic [15:0] sub;
		sub = st.presetSel[c] ? st.preset[c] : st.live[c];
		if (st.sleep)
			return st.preset[c];
		else if (flt || st.freeze)
			return sub;
		else if (st.mask[c])
			return st.preset[c];
		return st.live[c];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		s_d       = s_q;
		fault     = s_q.faultSync[1];
		s_d.faultSync = {s_q.faultSync[0], moduleFault};
		take      = sampleValid && !s_q.sleep;
		ch        = sampleChannel;
		winLen    = 8'h01 << s_q.smoothLog;
		full      = s_q.fill[ch] >= winLen;
		oldSample = hist[{ch, 7'(s_q.ptr[ch] - winLen[6:0])}];
		// a window of 128 wraps fully, so the slot read is the one replaced
		newSum    = $signed(s_q.sum[ch]) + 23'(sampleData)
			- (full ? 23'(oldSample) : 23'h00_0000);
		avgNow    = 16'(newSum >>> s_q.smoothLog);
		diff      = 17'(avgNow) - 17'($signed(s_q.refVal[ch]));
		diffAbs   = diff[16] ? 17'(-diff) : 17'(diff);
		changeHit = take && s_q.delta[ch] != aic_pkg::DELTA_RST
			&& diffAbs > {1'b0, s_q.delta[ch]};
		case (aic_pkg::aic_range_e'(s_q.range))
			aic_pkg::RNG_4_20MA, aic_pkg::RNG_1_5V:
				underLim = aic_pkg::UNDER_LIVE_ZERO;
			aic_pkg::RNG_0_5V:
				underLim = aic_pkg::UNDER_UNIPOLAR;
			default:
				underLim = aic_pkg::UNDER_BIPOLAR;
		endcase

		// mains pacing; the converter integrates over one period
		period   = s_q.mains60 ? 20'(CONV60_CYCLES) : 20'(CONV50_CYCLES);
		s_d.conv = 1'b0;
		if (s_q.sleep)
			s_d.tick = 20'h0_0000;
		else if (s_q.tick >= period - 20'h0_0001)
		begin
			s_d.tick = 20'h0_0000;
			s_d.conv = 1'b1;
		end
		else
			s_d.tick = s_q.tick + 20'h0_0001;

		// bus slave: one wait state, ack one cycle after the request
		req      = wb_cyc_i && wb_stb_i && !s_q.ack;
		wr       = req && wb_we_i;
		s_d.ack  = req;
		byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		bankCh   = wb_adr_i[5:2];
		bankOk   = 32'(bankCh) < CH;
		restart  = 1'b0;
		s_d.rdata = 32'h0000_0000;
		if (req && !wb_we_i)
		begin
			case (wb_adr_i[7:6])
				aic_pkg::DELTA_BANK:
					if (bankOk)
						s_d.rdata[15:0] = s_q.delta[bankCh];
				aic_pkg::PRESET_BANK:
					if (bankOk)
						s_d.rdata[15:0] = s_q.preset[bankCh];
				aic_pkg::VALUE_BANK:
					if (bankOk)
						s_d.rdata[15:0] = deliver(s_q, fault, 32'(bankCh));
				default:
					case (wb_adr_i)
						aic_pkg::CTRL_OFS:
							s_d.rdata[9:0] = {s_q.freeze, s_q.sleep, 1'b0,
								s_q.range, s_q.smoothLog, s_q.mains60};
						aic_pkg::STATUS_OFS:
							s_d.rdata[0] = fault;
						aic_pkg::PSEL_OFS:
							s_d.rdata[CH-1:0] = s_q.presetSel;
						aic_pkg::MASK_OFS:
							s_d.rdata[CH-1:0] = s_q.mask;
						aic_pkg::CALIB_OFS:
							s_d.rdata[CH-1:0] = s_q.calib;
						aic_pkg::INTSTAT_OFS:
							s_d.rdata[CH-1:0] = s_q.chg;
						aic_pkg::INTMASK_OFS:
							s_d.rdata[CH-1:0] = s_q.chgMask;
						aic_pkg::RANGE_OFS:
							s_d.rdata = {16'(s_q.over), 16'(s_q.under)};
						default:
							s_d.rdata = 32'h0000_0000;
					endcase
			endcase
		end
		if (wr)
		begin
			case (wb_adr_i[7:6])
				aic_pkg::DELTA_BANK:
					if (bankOk && wb_sel_i[1:0] != 2'h0)
						s_d.delta[bankCh] = (s_q.delta[bankCh]
							& ~byteMask[15:0]) | (wb_dat_i[15:0] & byteMask[15:0]);
				aic_pkg::PRESET_BANK:
					if (bankOk && wb_sel_i[1:0] != 2'h0)
						s_d.preset[bankCh] = (s_q.preset[bankCh]
							& ~byteMask[15:0]) | (wb_dat_i[15:0] & byteMask[15:0]);
				aic_pkg::VALUE_BANK:
					s_d.ack = req;
				default:
					case (wb_adr_i)
						aic_pkg::CTRL_OFS:
						begin
							if (wb_sel_i[0])
							begin
								s_d.mains60 =
									wb_dat_i[aic_pkg::CTRL_MAINS_BIT];
								s_d.smoothLog =
									wb_dat_i[aic_pkg::CTRL_SMOOTH_LSB +: 3];
								restart = s_d.smoothLog != s_q.smoothLog;
								s_d.range =
									wb_dat_i[aic_pkg::CTRL_RANGE_LSB +: 3];
							end
							if (wb_sel_i[1])
							begin
								s_d.sleep =
									wb_dat_i[aic_pkg::CTRL_SLEEP_BIT];
								s_d.freeze =
									wb_dat_i[aic_pkg::CTRL_FREEZE_BIT];
							end
						end
						aic_pkg::PSEL_OFS:
							s_d.presetSel = CH'((wb_dat_i & byteMask));
						aic_pkg::MASK_OFS:
							s_d.mask = CH'((wb_dat_i & byteMask));
						aic_pkg::CALIB_OFS:
							s_d.calib = CH'((wb_dat_i & byteMask));
						aic_pkg::INTSTAT_OFS:
							s_d.chg = s_q.chg & ~CH'((wb_dat_i & byteMask));
						aic_pkg::INTMASK_OFS:
							s_d.chgMask = CH'((wb_dat_i & byteMask));
						default:
							s_d.chgMask = s_d.chgMask;
					endcase
			endcase
		end

		// a new window length invalidates every running sum
		if (restart)
		begin
			s_d.fill = '0;
			s_d.sum  = '0;
		end
		else if (take)
		begin
			s_d.sum[ch]  = newSum;
			s_d.ptr[ch]  = s_q.ptr[ch] + 7'h01;
			if (!full)
				s_d.fill[ch] = s_q.fill[ch] + 8'h01;
			if (!s_q.calib[ch])
			begin
				s_d.under[ch] = 1'b1;
				s_d.over[ch]  = 1'b1;
			end
			else
			begin
				s_d.under[ch] = avgNow < underLim;
				s_d.over[ch]  = avgNow > aic_pkg::OVER_LIMIT;
			end
			if (changeHit)
			begin
				s_d.chg[ch]    = 1'b1;
				s_d.refVal[ch] = avgNow;
			end
			// hold-last: live value frozen while failed or frozen
			if (!(fault || s_q.freeze))
				s_d.live[ch] = avgNow;
		end
		s_d.irq = |(s_d.chg & s_d.chgMask);
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q           <= '0;
			s_q.mains60   <= aic_pkg::MAINS_RST;
			s_q.smoothLog <= aic_pkg::SMOOTH_RST;
			s_q.range     <= VOLTAGE_MODULE ? 3'(aic_pkg::RNG_BIP_5V)
				: 3'(aic_pkg::RNG_BIP_20MA);
			s_q.calib     <= '1;
		end
		else
			s_q <= s_d;
	end

	always_ff @(posedge clk)
	begin
		if (take && !restart)
			hist[{ch, s_q.ptr[ch]}] <= sampleData;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_valueRead(int c);
		req && !wb_we_i && wb_adr_i == {aic_pkg::VALUE_BANK, 4'(c), 2'h0};
	endsequence

	a_sleep_no_conv:
	assert property (s_q.sleep |=> !convStart)
		else $error("conversion started while asleep");
	a_conv_spacing:
	assert property (convStart |=> !convStart [*8])
		else $error("conversion pulses too close");
	a_over_limit:
	assert property (take && !restart && s_q.calib[ch]
		&& avgNow > 16'sd32256 |=> overRangeFlag[$past(ch)])
		else $error("over range not flagged");
	a_under_bip:
	assert property (take && !restart && s_q.calib[ch] && s_q.range == 3'h0
		&& avgNow >= -16'sd32256 |=> !underRangeFlag[$past(ch)])
		else $error("under range flagged inside limit");
	a_uncal_both:
	assert property (take && !restart && !s_q.calib[ch]
		|=> underRangeFlag[$past(ch)] && overRangeFlag[$past(ch)])
		else $error("uncalibrated channel lacks both flags");
	a_delta_off:
	assert property (changeHit |-> s_q.delta[ch] != 16'h0000)
		else $error("change flagged with zero delta");
	a_delta_ref:
	assert property (changeHit && !restart
		|=> s_q.refVal[$past(ch)] == $past(avgNow))
		else $error("reference not updated on change");
	a_sleep_preset:
	assert property (s_valueRead(0) ##0 s_q.sleep
		|=> wb_dat_o[15:0] == $past(s_q.preset[0]))
		else $error("sleep read not preset");
	a_mask_preset:
	assert property (s_valueRead(0) ##0 s_q.mask[0] && !s_q.sleep
		&& !fault && !s_q.freeze |=> wb_dat_o[15:0] == $past(s_q.preset[0]))
		else $error("masked read not preset");
	a_freeze_hold:
	assert property (s_q.freeze && take |=> $stable(s_q.live))
		else $error("live value moved while frozen");
	a_fail_hold:
	assert property (fault && take |=> $stable(s_q.live))
		else $error("live value moved during failure");
	a_ack_pulse:
	assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule

// ---- logic/aic_pkg.sv ----
package aic_pkg;
	localparam int CHANNELS = 16;

	// register byte offsets, one 32-bit word each
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] STATUS_OFS  = 8'h04;
	localparam logic [7:0] PSEL_OFS    = 8'h08;
	localparam logic [7:0] MASK_OFS    = 8'h0C;
	localparam logic [7:0] CALIB_OFS   = 8'h10;
	localparam logic [7:0] INTSTAT_OFS = 8'h14;
	localparam logic [7:0] INTMASK_OFS = 8'h18;
	localparam logic [7:0] RANGE_OFS   = 8'h1C;
	// per-channel banks: address[7:6], channel in address[5:2]
	localparam logic [1:0] DELTA_BANK  = 2'h1;
	localparam logic [1:0] PRESET_BANK = 2'h2;
	localparam logic [1:0] VALUE_BANK  = 2'h3;

	// control register fields
	localparam int CTRL_MAINS_BIT  = 0;
	localparam int CTRL_SMOOTH_LSB = 1;
	localparam int CTRL_RANGE_LSB  = 4;
	localparam int CTRL_SLEEP_BIT  = 8;
	localparam int CTRL_FREEZE_BIT = 9;

	typedef enum logic [2:0] {
		RNG_BIP_20MA,
		RNG_4_20MA,
		RNG_BIP_5V,
		RNG_0_5V,
		RNG_1_5V
	} aic_range_e;

	// values after reset
	localparam logic       MAINS_RST  = 1'b0;     // 50 Hz
	localparam logic [2:0] SMOOTH_RST = 3'h5;     // 32 samples
	localparam logic [15:0] DELTA_RST = 16'h0000; // check disabled

	// range limits, signed
	localparam logic signed [15:0] OVER_LIMIT      = 16'h7E00; // 32256
	localparam logic signed [15:0] UNDER_BIPOLAR   = 16'h8200; // -32256
	localparam logic signed [15:0] UNDER_LIVE_ZERO = 16'h1800; // 6144
	localparam logic signed [15:0] UNDER_UNIPOLAR  = 16'hFF00; // -256

	// conversion pacing: one integration per half mains period
	localparam int CLK_PERIOD_NS     = 10;
	localparam int MAINS50_PERIOD_US = 10000;
	localparam int MAINS60_PERIOD_US = 8330;
	localparam int CONV50_CYCLES = MAINS50_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int CONV60_CYCLES = MAINS60_PERIOD_US * 1000 / CLK_PERIOD_NS;
endpackage

// ---- verification/aic_converter_model.sv ----
`timescale 1ns/1ns
// converter stand-in: one burst of all channels per conversion start
module aic_converter_model #(
	parameter int CH = 8
) (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic                  convStart,
	input  wire logic signed [15:0]    level,
	output logic                       sampleValid,
	output logic [$clog2(CH)-1:0]      sampleChannel,
	output logic signed [15:0]         sampleData
);
	localparam int CW = $clog2(CH);
	int cnt;
	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt <= CH;
			sampleValid <= 1'b0;
			sampleChannel <= '0;
			sampleData <= 16'h0000;
		end
		else if (convStart || cnt < CH)
		begin
			cnt <= convStart ? 1 : cnt + 1;
			sampleValid <= 1'b1;
			sampleChannel <= convStart ? '0 : CW'(cnt);
			sampleData <= level;
		end
		else
		begin
			// idle data keeps moving so a stale sample cannot pass
			sampleValid <= 1'b0;
			sampleData <= ~sampleData;
		end
	end
endmodule

// ---- verification/aic_conditioner_bench.sv ----
`timescale 1ns/1ns
module aic_conditioner_bench;
	localparam int CH = 8;
	typedef struct packed {
		logic [7:0]  adr;
		logic [31:0] exp;
	} aic_row_s;
	logic               clk = 1'b0;
	logic               resetN = 1'b0;
	logic               wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0]         wbAdr = 8'h00;
	logic [3:0]         wbSel = 4'hF;
	logic [31:0]        wbDat = 32'h0000_0000, wbDatO, rdat;
	logic               wbAck, irq, convStart, sampleValid, moduleFault = 1'b0;
	logic [2:0]         sampleChannel;
	logic signed [15:0] sampleData, level = 16'h0000;
	logic [CH-1:0]      underRangeFlag, overRangeFlag;
	int                 failures = 0, samplesChecked = 0, cycles = 0, n;
	aic_row_s rows [10] = '{
		'{8'h00, 32'h0000_000A}, '{8'h04, 32'h0000_0000},
		'{8'h08, 32'h0000_0000}, '{8'h0C, 32'h0000_0000},
		'{8'h10, 32'h0000_00FF}, '{8'h14, 32'h0000_0000},
		'{8'h18, 32'h0000_0000}, '{8'h1C, 32'h0000_0000},
		'{8'h40, 32'h0000_0000}, '{8'h20, 32'h0000_0000}};
	always #5 clk = ~clk;
	//////////////////////////////////////////////////////////////////////
	aic_conditioner #(.CH(CH), .CONV50_CYCLES(20), .CONV60_CYCLES(16)) DUT (
		.clk(clk), .reset_n(resetN),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq(irq),
		.convStart(convStart), .sampleValid(sampleValid),
		.sampleChannel(sampleChannel), .sampleData(sampleData),
		.moduleFault(moduleFault), .underRangeFlag(underRangeFlag),
		.overRangeFlag(overRangeFlag));
	aic_converter_model #(.CH(CH)) conv (
		.clk(clk), .reset_n(resetN), .convStart(convStart),
		.level(level), .sampleValid(sampleValid),
		.sampleChannel(sampleChannel), .sampleData(sampleData));
	//////////////////////////////////////////////////////////////////////
	task summarize();
		if (failures == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDat <= d;
		wbSel <= s;
		do @(posedge clk); while (wbAck !== 1'b1);
		rdat = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000, 4'hF);
		chk(rdat, e);
	endtask
	// no fixed latency assumed: wait for the pulse, then the whole burst
	task cv(input int k);
		repeat (k)
		begin
			do @(posedge clk); while (convStart !== 1'b1);
		end
		repeat (CH + 3) @(posedge clk);
	endtask
	task lv(input logic signed [15:0] x);
		@(posedge clk);
		level <= x;
		cv(2);
	endtask
	task fl(input logic [1:0] e);
		chk({30'h0, underRangeFlag[0], overRangeFlag[0]}, {30'h0, e});
	endtask
	task per(input int e);
		do @(posedge clk); while (convStart !== 1'b1);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (convStart !== 1'b1);
		chk(n, e);
	endtask
	//////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			summarize();
		end
	end
	initial
	begin
		repeat (5) @(posedge clk);
		resetN <= 1'b1;
		foreach (rows[i])
			rdc(rows[i].adr, rows[i].exp);
		wr(8'h00, 32'h0000_0000);
		lv(16'sd1000);
		rdc(8'hC0, 32'h0000_03E8);
		rdc(8'hDC, 32'h0000_03E8);
		lv(16'sd32257);
		fl(2'b01);
		lv(16'sd32256);
		fl(2'b00);
		lv(-16'sd32257);
		fl(2'b10);
		lv(-16'sd32256);
		fl(2'b00);
		wr(8'h10, 32'h0000_00FE);
		cv(2);
		fl(2'b11);
		wr(8'h10, 32'h0000_00FF);
		wr(8'h00, 32'h0000_0010);
		lv(16'sd6143);
		fl(2'b10);
		lv(16'sd6144);
		fl(2'b00);
		wr(8'h00, 32'h0000_0030);
		lv(-16'sd257);
		fl(2'b10);
		lv(-16'sd256);
		fl(2'b00);
		lv(16'sd32257);
		fl(2'b01);
		wr(8'h00, 32'h0000_0040);
		lv(16'sd6143);
		fl(2'b10);
		lv(16'sd6144);
		fl(2'b00);
		wr(8'h00, 32'h0000_0000);
		per(20);
		wr(8'h00, 32'h0000_0001);
		per(16);
		wr(8'h00, 32'h0000_0000);
		lv(16'sd0);
		wr(8'h40, 32'h0000_0064);
		lv(16'sd100);
		rdc(8'h14, 32'h0000_0000);
		lv(16'sd101);
		rdc(8'h14, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(8'h18, 32'h0000_0001);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(8'h14, 32'h0000_0001);
		cv(1);
		rdc(8'h14, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		lv(16'sd150);
		rdc(8'h14, 32'h0000_0000);
		lv(16'sd202);
		rdc(8'h14, 32'h0000_0001);
		wr(8'h14, 32'h0000_0001);
		wr(8'h80, 32'h0000_1234);
		wr(8'h0C, 32'h0000_0001);
		cv(2);
		rdc(8'hC0, 32'h0000_1234);
		wr(8'h0C, 32'h0000_0000);
		cv(2);
		rdc(8'hC0, 32'h0000_00CA);
		moduleFault <= 1'b1;
		cv(1);
		lv(16'sd500);
		rdc(8'h04, 32'h0000_0001);
		rdc(8'hC0, 32'h0000_00CA);
		wr(8'h08, 32'h0000_0001);
		cv(2);
		rdc(8'hC0, 32'h0000_1234);
		moduleFault <= 1'b0;
		wr(8'h08, 32'h0000_0000);
		cv(2);
		rdc(8'hC0, 32'h0000_01F4);
		wr(8'h00, 32'h0000_0200);
		lv(16'sd600);
		rdc(8'hC0, 32'h0000_01F4);
		wr(8'h00, 32'h0000_0000);
		cv(2);
		wb(1'b1, 8'h00, 32'h0000_0200, 4'h1);
		rdc(8'h00, 32'h0000_0000);
		wr(8'h00, 32'h0000_0100);
		n = 0;
		repeat (60)
		begin
			@(posedge clk);
			if (convStart === 1'b1)
				n++;
		end
		chk(n, 0);
		rdc(8'hC0, 32'h0000_1234);
		rdc(8'hC4, 32'h0000_0000);
		wr(8'hC0, 32'h0000_FFFF);
		wr(8'h00, 32'h0000_0000);
		cv(2);
		rdc(8'hC0, 32'h0000_0258);
		// missing samples count as zero, so one sample gives level/128
		lv(16'sd1280);
		wr(8'h00, 32'h0000_000E);
		cv(1);
		rdc(8'hC0, 32'h0000_000A);
		cv(1);
		rdc(8'hC0, 32'h0000_0014);
		resetN <= 1'b0;
		repeat (2) @(posedge clk);
		resetN <= 1'b1;
		rdc(8'h00, 32'h0000_000A);
		rdc(8'h40, 32'h0000_0000);
		summarize();
	end
endmodule
